// >>> sleep_wakeup_pkg.sv
`default_nettype none
package sleep_wakeup_pkg;
   // clock and timing
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned WDOG_PERIOD_MS = 18;
   localparam int unsigned RDLY_POR_MS = 18;
   localparam int unsigned RDLY_SUB_US = 10;
   // watchdog period rounds down, reset delays round up
   localparam int unsigned WDOG_CYCLES = (WDOG_PERIOD_MS * CLK_HZ) / 1000;
   localparam int unsigned RDLY_POR_CYCLES = (RDLY_POR_MS * CLK_HZ + 999) / 1000;
   localparam int unsigned RDLY_SUB_CYCLES = (RDLY_SUB_US * CLK_HZ + 999_999) / 1_000_000;
   localparam int unsigned CNT_W = 20;
   // register map, byte addresses
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   // status word bit positions
   localparam int unsigned ST_SLEEP_BIT = 0;
   localparam int unsigned ST_RESET_BIT = 1;
   localparam int unsigned ST_PWRDN_BIT = 3;
   localparam int unsigned ST_TMO_BIT = 4;
   localparam int unsigned ST_PCW_BIT = 7;
   localparam int unsigned CTRL_W = 7;
   localparam logic [6:0] CTRL_RESET = 7'h7B;
   localparam logic [2:0] FLAGS_POR = 3'h3;
   // control word: bit0 wdog_en, 1 xrst_en, 2 woc_en, 3 psa, 6:4 ps
   typedef struct packed {
      logic [2:0] ps;
      logic psa;
      logic woc_en;
      logic xrst_en;
      logic wdog_en;
   } ctrl_s;
   typedef struct packed {
      logic pin_change_wake_flag;
      logic timeout_flag_n;
      logic powerdown_flag_n;
   } flags_s;
   typedef enum {ST_RUN, ST_SLEEP, ST_HOLD, ST_DELAY} pstate_e;
endpackage
`default_nettype wire

// >>> reload_counter.sv
`default_nettype none
module reload_counter #(
   parameter int unsigned WIDTH = 20,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [WIDTH-1:0] load_value,
   input wire logic dec,
   output var logic [WIDTH-1:0] count_q,
   output logic zero
);
   // load wins over counting, counting stops at zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= RESET_VALUE;
      end else if (load) begin
         count_q <= load_value;
      end else if (dec && !zero) begin
         count_q <= count_q - WIDTH'(1);
      end
   end

   assign zero = (count_q == '0);

   AST_LOAD_TAKES: assert property (@(posedge clk) disable iff (!rst_n)
      load |=> count_q == $past(load_value))
      else $error("counter did not take its load value");
endmodule
`default_nettype wire

// >>> sleep_wakeup_control.sv
// Contract
// - power-down entered only by sleep instruction
// - sleep with watchdog: clear it, set timeout
// - sleep clears powerdown flag, stops oscillator
// - pins keep drive state during sleep
// - watchdog reset stays internal, pin untouched
// - wake on reset pin, watchdog, pin change
// - every wake is a full device reset
// - watchdog timeout clears the timeout flag
// - powerdown flag set at power-up, cleared by sleep
// - pin change during sleep sets wake flag
// - mismatch present at sleep wakes at once
// - watchdog cleared on every wake
// - flags encode the reset cause
// - reset pin pulse leaves flags unchanged
// - watchdog wake starts reset delay timer
// - sleep clears prescaler when assigned to watchdog
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`default_nettype none
module sleep_wakeup_control #(
   parameter int unsigned NPINS = 4,
   parameter int unsigned CNT_W = sleep_wakeup_pkg::CNT_W,
   parameter int unsigned WDOG_CYCLES = sleep_wakeup_pkg::WDOG_CYCLES,
   parameter int unsigned RDLY_POR_CYCLES = sleep_wakeup_pkg::RDLY_POR_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic sleep_instr,
   input wire logic clrwdt_instr,
   input wire logic port_access,
   input wire logic [NPINS-1:0] wake_pins,
   input wire logic external_reset_pin_n,
   input wire logic [NPINS-1:0] port_out,
   input wire logic [NPINS-1:0] port_oe_n,
   output var logic [NPINS-1:0] io_out_q,
   output var logic [NPINS-1:0] io_oe_n_q,
   output var logic core_reset_q,
   output var logic osc_drive_en_q,
   output var logic sleep_q,
   output var sleep_wakeup_pkg::flags_s flags_q
);
   sleep_wakeup_pkg::pstate_e state_q, state_d;
   sleep_wakeup_pkg::ctrl_s ctrl_q;
   sleep_wakeup_pkg::flags_s flags_d;
   logic [NPINS-1:0] pins_m_q, pins_s_q, ref_q;
   logic rst_m_q, rst_s_q;
   logic [6:0] pre_q, pre_d, pre_lim;
   logic [7:0] addr_q;
   logic wr_q;
   logic [31:0] hrdata_q, rd_word, status_word;
   logic [CNT_W-1:0] wdog_cnt, rdly_cnt;
   logic wdog_zero, rdly_zero;

   // pin inputs pass two flops before use
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pins_m_q <= '0;
         pins_s_q <= '0;
         rst_m_q <= 1'b1;
         rst_s_q <= 1'b1;
      end else begin
         pins_m_q <= wake_pins;
         pins_s_q <= pins_m_q;
         rst_m_q <= external_reset_pin_n;
         rst_s_q <= rst_m_q;
      end
   end

   // event decode
   wire active = (state_q == sleep_wakeup_pkg::ST_RUN) || (state_q == sleep_wakeup_pkg::ST_SLEEP);
   wire in_sleep = (state_q == sleep_wakeup_pkg::ST_SLEEP);
   wire in_run = (state_q == sleep_wakeup_pkg::ST_RUN);
   wire ext_rst = ctrl_q.xrst_en && !rst_s_q;
   wire [NPINS-1:0] mismatch = pins_s_q ^ ref_q;
   wire base_tick = ctrl_q.wdog_en && active && wdog_zero;
   wire pre_hit = !ctrl_q.psa || (pre_q == pre_lim);
   wire wdog_to = base_tick && pre_hit && !ext_rst;
   // only the sleep instruction enters sleep
   wire sleep_go = sleep_instr && in_run && !ext_rst && !wdog_to;
   wire clrwdt_go = clrwdt_instr && in_run && !ext_rst;
   wire pin_wake = in_sleep && ctrl_q.woc_en && (|mismatch) && !ext_rst && !wdog_to;
   // any of the three sources wakes
   wire wake = in_sleep && (ext_rst || wdog_to || pin_wake);
   wire wdog_clear = sleep_go || clrwdt_go || wake || !active || !ctrl_q.wdog_en;
   wire enter_delay = (state_d == sleep_wakeup_pkg::ST_DELAY) &&
                      (state_q != sleep_wakeup_pkg::ST_DELAY);

   // power state sequencing
   always_comb begin
      state_d = state_q;
      case (state_q)
         sleep_wakeup_pkg::ST_RUN: begin
            if (ext_rst) begin
               state_d = sleep_wakeup_pkg::ST_HOLD;
            end else if (wdog_to) begin
               state_d = sleep_wakeup_pkg::ST_DELAY;
            end else if (sleep_go) begin
               state_d = sleep_wakeup_pkg::ST_SLEEP;
            end
         end
         sleep_wakeup_pkg::ST_SLEEP: begin
            if (ext_rst) begin
               state_d = sleep_wakeup_pkg::ST_HOLD;
            end else if (wdog_to || pin_wake) begin
               state_d = sleep_wakeup_pkg::ST_DELAY;
            end
         end
         sleep_wakeup_pkg::ST_HOLD: begin
            if (!ext_rst) begin
               state_d = sleep_wakeup_pkg::ST_DELAY;
            end
         end
         sleep_wakeup_pkg::ST_DELAY: begin
            if (ext_rst) begin
               state_d = sleep_wakeup_pkg::ST_HOLD;
            end else if (rdly_zero) begin
               state_d = sleep_wakeup_pkg::ST_RUN;
            end
         end
         default: state_d = sleep_wakeup_pkg::ST_DELAY;
      endcase
   end

   // state and power outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= sleep_wakeup_pkg::ST_DELAY;
         core_reset_q <= 1'b1;
         osc_drive_en_q <= 1'b1;
         sleep_q <= 1'b0;
      end else begin
         state_q <= state_d;
         core_reset_q <= (state_d == sleep_wakeup_pkg::ST_HOLD) ||
                         (state_d == sleep_wakeup_pkg::ST_DELAY);
         osc_drive_en_q <= (state_d != sleep_wakeup_pkg::ST_SLEEP);
         sleep_q <= (state_d == sleep_wakeup_pkg::ST_SLEEP);
      end
   end

   // reset delay timer, long count from power-up
   // timeout wake reloads the delay
   reload_counter #(
      .WIDTH(CNT_W),
      .RESET_VALUE(CNT_W'(RDLY_POR_CYCLES))
   ) u_rdly (
      .clk(hclk),
      .rst_n(hresetn),
      .load(enter_delay),
      .load_value(CNT_W'(sleep_wakeup_pkg::RDLY_SUB_CYCLES)),
      .dec(state_q == sleep_wakeup_pkg::ST_DELAY),
      .count_q(rdly_cnt),
      .zero(rdly_zero)
   );

   // watchdog base period counter
   // sleep clears the running watchdog
   reload_counter #(
      .WIDTH(CNT_W),
      .RESET_VALUE(CNT_W'(WDOG_CYCLES - 1))
   ) u_wdog (
      .clk(hclk),
      .rst_n(hresetn),
      .load(wdog_clear || base_tick),
      .load_value(CNT_W'(WDOG_CYCLES - 1)),
      .dec(ctrl_q.wdog_en),
      .count_q(wdog_cnt),
      .zero(wdog_zero)
   );

   // prescaler divides watchdog periods when assigned
   assign pre_lim = 7'((8'h01 << ctrl_q.ps) - 8'h01);
   assign pre_d = (wdog_clear || !ctrl_q.psa) ? 7'h00 :
                  base_tick ? (pre_hit ? 7'h00 : pre_q + 7'h01) : pre_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_q <= 7'h00;
      end else begin
         pre_q <= pre_d;
      end
   end

   // status flag updates, hardware events only
   // power-up value comes from reset
   always_comb begin
      flags_d = flags_q;
      if (wdog_to) begin
         flags_d.timeout_flag_n = 1'b0;
         flags_d.pin_change_wake_flag = 1'b0;
      end else if (sleep_go) begin
         if (ctrl_q.wdog_en) begin
            flags_d.timeout_flag_n = 1'b1;
         end
         flags_d.powerdown_flag_n = 1'b0;
         flags_d.pin_change_wake_flag = 1'b0;
      end else if (clrwdt_go) begin
         flags_d.timeout_flag_n = 1'b1;
         flags_d.powerdown_flag_n = 1'b1;
      end else if (pin_wake) begin
         flags_d.pin_change_wake_flag = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_q <= sleep_wakeup_pkg::FLAGS_POR;
      end else begin
         flags_q <= flags_d;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_q <= '0;
      end else if (port_access && in_run) begin
         ref_q <= pins_s_q;
      end
   end

   wire io_hold = in_sleep || sleep_go;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         io_out_q <= '0;
         io_oe_n_q <= '1;
      end else if (core_reset_q) begin
         io_oe_n_q <= '1;
      end else if (!io_hold) begin
         io_out_q <= port_out;
         io_oe_n_q <= port_oe_n;
      end
   end

   // ahb-lite slave, zero wait states
   wire addr_ph = hsel && htrans[1] && hready;
   wire ctrl_wr = wr_q && (addr_q == sleep_wakeup_pkg::CTRL_OFF);
   wire [6:0] ctrl_now = ctrl_wr ? hwdata[6:0] : ctrl_q;

   assign status_word = (32'(flags_q.pin_change_wake_flag) << sleep_wakeup_pkg::ST_PCW_BIT) |
                        (32'(flags_q.timeout_flag_n) << sleep_wakeup_pkg::ST_TMO_BIT) |
                        (32'(flags_q.powerdown_flag_n) << sleep_wakeup_pkg::ST_PWRDN_BIT) |
                        (32'(core_reset_q) << sleep_wakeup_pkg::ST_RESET_BIT) |
                        (32'(sleep_q) << sleep_wakeup_pkg::ST_SLEEP_BIT);
   assign rd_word = (haddr[7:0] == sleep_wakeup_pkg::CTRL_OFF) ? {25'h0000000, ctrl_now} :
                    (haddr[7:0] == sleep_wakeup_pkg::STATUS_OFF) ? status_word : 32'h00000000;

   // address phase capture and read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q <= 8'h00;
         wr_q <= 1'b0;
         hrdata_q <= 32'h00000000;
      end else begin
         wr_q <= addr_ph && hwrite && (haddr[31:8] == 24'h000000);
         addr_q <= haddr[7:0];
         if (addr_ph && !hwrite) begin
            hrdata_q <= (haddr[31:8] == 24'h000000) ? rd_word : 32'h00000000;
         end
      end
   end

   // control register write in data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= sleep_wakeup_pkg::CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_q <= hwdata[6:0];
      end
   end

   // fixed okay response, always ready
   logic hreadyout_q, hresp_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end else begin
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end
   end

   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;
   assign hrdata = hrdata_q;

   // checks
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   AST_SLEEP_ONLY_BY_INSTR: assert property (
      $rose(sleep_q) |-> $past(sleep_instr))
      else $error("sleep entered without sleep instruction");
   AST_SLEEP_SETS_TIMEOUT: assert property (
      (sleep_go && ctrl_q.wdog_en) |=> flags_q.timeout_flag_n &&
                                      wdog_cnt == CNT_W'(WDOG_CYCLES - 1))
      else $error("sleep did not set timeout flag or clear watchdog");
   AST_SLEEP_PD_OSC: assert property (
      sleep_go |=> !flags_q.powerdown_flag_n && !osc_drive_en_q)
      else $error("sleep did not clear powerdown flag or stop oscillator");
   AST_IO_HOLD: assert property (
      (sleep_q && $past(sleep_q)) |-> $stable(io_out_q) && $stable(io_oe_n_q))
      else $error("pin drive changed during sleep");
   AST_WDOG_WAKE_RESET: assert property (
      (wdog_to && in_sleep) |=> !flags_q.timeout_flag_n && !flags_q.powerdown_flag_n
                                ##1 core_reset_q && rdly_cnt != '0)
      else $error("watchdog wake did not reset with delay");
   AST_PIN_WAKE_FLAG: assert property (
      pin_wake |=> flags_q.pin_change_wake_flag ##1 core_reset_q && !sleep_q)
      else $error("pin change wake not flagged");
   AST_WAKE_CLEARS_WDOG: assert property (
      wake |=> wdog_cnt == CNT_W'(WDOG_CYCLES - 1))
      else $error("watchdog not cleared on wake");
   AST_EXT_RESET_FLAGS: assert property (
      ext_rst |=> $stable(flags_q))
      else $error("reset pin changed a status flag");
   AST_PRESCALER_CLEAR: assert property (
      (sleep_go && ctrl_q.psa) |=> pre_q == 7'h00)
      else $error("sleep did not clear prescaler");
   AST_SNAPSHOT: assert property (
      (port_access && in_run) |=> ref_q == $past(pins_s_q))
      else $error("port access did not snapshot pins");

   COV_WDOG_WAKE: cover property (wdog_to && in_sleep);
   COV_PIN_WAKE: cover property (pin_wake);
   COV_EXT_WAKE: cover property (ext_rst && in_sleep);
   COV_RELEASE: cover property ($fell(core_reset_q));
endmodule
`default_nettype wire

// >>> testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int WDOG = 50;
   localparam int RDLY_POR = 30;
   localparam int RDLY_SUB = sleep_wakeup_pkg::RDLY_SUB_CYCLES;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic hwrite;
   logic hready;
   logic hreadyout;
   logic hresp;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [2:0] ev;
   logic sleep_instr;
   logic clrwdt_instr;
   logic port_access;
   logic external_reset_pin_n;
   logic core_reset_q;
   logic osc_drive_en_q;
   logic sleep_q;
   logic [3:0] wake_pins;
   logic [3:0] port_out;
   logic [3:0] port_oe_n;
   logic [3:0] io_out_q;
   logic [3:0] io_oe_n_q;
   sleep_wakeup_pkg::flags_s flags_q;
   int failures;
   int samples_checked;
   int n;
   logic [31:0] rd;

   // one slave: its ready is the bus ready; core events come from one vector
   assign hready = hreadyout;
   assign {port_access, clrwdt_instr, sleep_instr} = ev;

   sleep_wakeup_control #(
      .NPINS(4),
      .WDOG_CYCLES(WDOG),
      .RDLY_POR_CYCLES(RDLY_POR)
   ) DUT (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .sleep_instr(sleep_instr),
      .clrwdt_instr(clrwdt_instr),
      .port_access(port_access),
      .wake_pins(wake_pins),
      .external_reset_pin_n(external_reset_pin_n),
      .port_out(port_out),
      .port_oe_n(port_oe_n),
      .io_out_q(io_out_q),
      .io_oe_n_q(io_oe_n_q),
      .core_reset_q(core_reset_q),
      .osc_drive_en_q(osc_drive_en_q),
      .sleep_q(sleep_q),
      .flags_q(flags_q)
   );

   // 40 MHz clock
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   // verdict and end of run
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // compare one value, four-state exact
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, msg, got, exp);
      end
   endtask

   // single ahb transfer, entered just after a rising edge
   task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                      output logic [31:0] rdv);
      int k;
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= addr;
      hwrite <= wr;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hready !== 1'b1 && k < 100);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hready !== 1'b1 && k < 100);
      rdv = hrdata;
      chk({31'h0, hready}, 32'h1, "ready level");
      chk({31'h0, hresp}, 32'h0, "response code");
   endtask

   // one-cycle event pulse, returns after the edge that samples it
   task automatic pulse(input logic [2:0] m);
      ev <= m;
      @(posedge hclk);
      ev <= 3'b000;
   endtask

   // bounded wait for the core reset level, ends just after a rising edge
   task automatic wait_core(input logic v, input int max, output int cnt);
      cnt = 0;
      @(negedge hclk);
      while (core_reset_q !== v && cnt < max) begin
         @(negedge hclk);
         cnt++;
      end
      chk({31'h0, core_reset_q}, {31'h0, v}, "core reset level");
      @(posedge hclk);
   endtask

   // flags and sleep outputs sampled mid-cycle
   task automatic look(input logic [2:0] f, input logic s, input string msg);
      @(negedge hclk);
      chk({29'h0, flags_q}, {29'h0, f}, msg);
      chk({31'h0, sleep_q}, {31'h0, s}, msg);
      @(posedge hclk);
   endtask

   // hang guard
   initial begin
      #500000;
      failures++;
      wrap_up();
   end

   // main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      ev = 3'h0;
      wake_pins = 4'h0;
      external_reset_pin_n = 1'b1;
      port_out = 4'h0;
      port_oe_n = 4'hF;
      failures = 0;
      samples_checked = 0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      look(3'b011, 1'b0, "power-up flags");
      ahb(1'b0, 32'h00, 32'h0, rd);
      chk(rd, 32'h7B, "ctrl reset value");
      ahb(1'b1, 32'h10, 32'hFFFF_FFFF, rd);
      ahb(1'b0, 32'h10, 32'h0, rd);
      chk(rd, 32'h0, "unmapped read");
      wait_core(1'b0, RDLY_POR + 20, n);
      repeat (20) @(posedge hclk);
      look(3'b011, 1'b0, "no sleep without instruction");
      ahb(1'b1, 32'h00, 32'h06, rd);
      ahb(1'b0, 32'h00, 32'h0, rd);
      chk(rd, 32'h06, "ctrl readback");
      // sleep keeps pins, pin change wakes with full reset
      port_out <= 4'hA;
      port_oe_n <= 4'h3;
      pulse(3'b100);
      pulse(3'b001);
      @(negedge hclk);
      chk({31'h0, osc_drive_en_q}, 32'h0, "oscillator off");
      @(posedge hclk);
      look(3'b010, 1'b1, "sleep entry flags");
      port_out <= 4'h5;
      port_oe_n <= 4'hC;
      repeat (5) @(posedge hclk);
      @(negedge hclk);
      chk({28'h0, io_out_q}, 32'hA, "pin value held");
      chk({28'h0, io_oe_n_q}, 32'h3, "pin drive held");
      @(posedge hclk);
      wake_pins <= 4'h1;
      wait_core(1'b1, 20, n);
      look(3'b110, 1'b0, "pin change wake");
      ahb(1'b0, 32'h04, 32'h0, rd);
      chk(rd, 32'h92, "status during delay");
      chk({28'h0, io_oe_n_q}, 32'hF, "pins released in reset");
      chk({31'h0, osc_drive_en_q}, 32'h1, "oscillator on");
      wait_core(1'b0, RDLY_SUB + 20, n);
      // stale mismatch wakes at once
      wake_pins <= 4'h0;
      repeat (3) @(posedge hclk);
      pulse(3'b100);
      wake_pins <= 4'h1;
      repeat (3) @(posedge hclk);
      pulse(3'b001);
      wait_core(1'b1, 10, n);
      look(3'b110, 1'b0, "immediate wake");
      wait_core(1'b0, RDLY_SUB + 20, n);
      // port read just before sleep avoids the instant wake
      pulse(3'b100);
      pulse(3'b001);
      repeat (30) @(posedge hclk);
      @(negedge hclk);
      chk({31'h0, core_reset_q}, 32'h0, "no wake after fresh read");
      @(posedge hclk);
      look(3'b010, 1'b1, "still asleep");
      // reset pin wake, then pulse while awake
      external_reset_pin_n <= 1'b0;
      wait_core(1'b1, 10, n);
      look(3'b010, 1'b0, "reset pin wake");
      external_reset_pin_n <= 1'b1;
      wait_core(1'b0, RDLY_SUB + 20, n);
      external_reset_pin_n <= 1'b0;
      wait_core(1'b1, 10, n);
      external_reset_pin_n <= 1'b1;
      wait_core(1'b0, RDLY_SUB + 20, n);
      look(3'b010, 1'b0, "reset pin keeps flags");
      // watchdog: timeout awake, sleep, timeout wake, clear
      ahb(1'b1, 32'h00, 32'h03, rd);
      wait_core(1'b1, WDOG + 20, n);
      look(3'b000, 1'b0, "awake timeout");
      wait_core(1'b0, RDLY_SUB + 20, n);
      pulse(3'b001);
      look(3'b010, 1'b1, "sleep with watchdog");
      wait_core(1'b1, WDOG + 20, n);
      look(3'b000, 1'b0, "watchdog wake");
      wait_core(1'b0, RDLY_SUB + 20, n);
      chk({31'h0, (n >= RDLY_SUB - 5 && n <= RDLY_SUB + 10)}, 32'h1, "reset delay");
      pulse(3'b010);
      look(3'b011, 1'b0, "clear watchdog flags");
      wait_core(1'b1, WDOG + 20, n);
      look(3'b001, 1'b0, "timeout keeps pd");
      // prescaler of two stretches the timeout past one base period
      wait_core(1'b0, RDLY_SUB + 20, n);
      ahb(1'b1, 32'h00, 32'h1B, rd);
      wait_core(1'b1, 2 * WDOG + 20, n);
      chk({31'h0, (n > WDOG)}, 32'h1, "prescaled timeout");
      wrap_up();
   end
endmodule
`default_nettype wire
